// ### verilog/mdhc_defines.svh
// Timing counts and field constants for the DAC host control block
`ifndef MDHC_DEFINES_SVH
`define MDHC_DEFINES_SVH
`define MDHC_CLK_MHZ 100
`define MDHC_CLR_US_16CH 20
`define MDHC_CLR_US_8CH 15
`define MDHC_RST_US 270
`define MDHC_CALC_CYC 16'h0040
`define MDHC_CLR_CYC_16CH (`MDHC_CLR_US_16CH * `MDHC_CLK_MHZ)
`define MDHC_CLR_CYC_8CH (`MDHC_CLR_US_8CH * `MDHC_CLK_MHZ)
`define MDHC_RST_CYC (`MDHC_RST_US * `MDHC_CLK_MHZ)
`define MDHC_FRAME_BITS 24
`define MDHC_I2C_ADDR_HI 5'h15
`define MDHC_CH_BITS 4
`define MDHC_DATA_BITS 14
`define MDHC_FIFO_DEPTH 4
`endif

// ### verilog/mdhc_pkg.sv
// Types for the DAC host control block
package mdhc_pkg;
	typedef enum logic [2:0] {MDHC_IDLE, MDHC_CALC, MDHC_CLEAR, MDHC_RESET} mdhc_state_t;
	typedef enum logic [1:0] {MDHC_REG_SFR, MDHC_REG_GAIN, MDHC_REG_OFFS, MDHC_REG_INPUT} mdhc_reg_t;
endpackage

// ### verilog/mdhc_ctrl.sv
// Digital control of a multichannel DAC: serial link, load, clear, reset, busy, power-down
// Contract
// - Frame low enables bit count, then update
// - I2C mode: frame and chain pins address
// - Chain select high forwards shifted data out
// - Serial out changes on rising clock edge
// - During calculation writes queue, no DAC update
// - Load pulse when idle transfers inputs
// - Load pulse during calculation remembered, applied later
// - Reset: busy low, interface off, loads dropped
// - Clear acts on fall; loads ignored while low
// - Clear loads clear code, busy timed
// - Reset fall restores defaults within limit
// - Busy low through whole reset sequence
// - After reset, only new fall restarts
// - Power-down level selects output low-power state
// - Serial interface works while powered down
// - Select low is I2C, high serial
// - Serial clock supported up to 50 MHz
// - I2C works at 100 and 400 kHz; here no word is taken in I2C mode and sda_oe is tied low
// - I2C data pin drives low only
// - Monitor selector routes inputs or channels
`timescale 1ns/1ps
`include "mdhc_defines.svh"
module mdhc_ctrl
	import mdhc_pkg::*;
#(
	parameter int CLR_CYC = `MDHC_CLR_CYC_16CH,
	parameter int RST_CYC = `MDHC_RST_CYC
)
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic serial_clk,
	input wire logic iface_spi_sel,
	input wire logic frame_n,
	input wire logic chain_enable,
	input wire logic serial_in,
	output logic sda_o,
	output logic sda_oe,
	output logic serial_out,
	output logic serial_out_oe,
	input wire logic load_outputs_n,
	input wire logic clear_n,
	input wire logic reset_n,
	input wire logic power_down,
	input wire logic pd_mode_load,
	output logic busy_n,
	output logic out_hiz,
	output logic out_load_gnd,
	input wire logic [4:0] monitor_sel,
	output logic [4:0] monitor_route,
	output logic [1:0] bus_addr,
	output logic [23:0] last_word,
	output logic dac_update
);
	localparam int FB = `MDHC_FRAME_BITS;

	// Serial clock domain: the frame bit counter and shifters
	logic [FB-1:0] shift_r, shift_nxt;
	logic [4:0] bitcnt_r, bitcnt_nxt;
	logic word_tgl_r, word_tgl_nxt;
	logic [FB-1:0] word_r, word_nxt;
	logic so_r;
	logic spi_mode_lk;

	// Clear of bit count comes from frame level itself, sampled in the link domain
	assign spi_mode_lk = iface_spi_sel;

	always_comb
	begin
		shift_nxt = shift_r;
		bitcnt_nxt = bitcnt_r;
		word_tgl_nxt = word_tgl_r;
		word_nxt = word_r;
		// Frame high clears the count, so a cut frame leaves no partial word behind
		if (frame_n || !spi_mode_lk)
		begin
			bitcnt_nxt = 5'h00;
		end
		else
		begin
			shift_nxt = {shift_r[FB-2:0], serial_in};
			if (bitcnt_r == 5'(FB - 1))
			begin
				bitcnt_nxt = 5'h00;
				word_nxt = shift_nxt;
				// Toggle instead of pulse: the link clock may stop right after the word
				word_tgl_nxt = ~word_tgl_r;
			end
			else
			begin
				bitcnt_nxt = bitcnt_r + 5'h01;
			end
		end
	end

	// The link clock only runs inside frames, so its reset cannot wait for an edge
	always_ff @(negedge serial_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			shift_r <= 24'h000000;
			bitcnt_r <= 5'h00;
			word_tgl_r <= 1'b0;
			word_r <= 24'h000000;
		end
		else
		begin
			shift_r <= shift_nxt;
			bitcnt_r <= bitcnt_nxt;
			word_tgl_r <= word_tgl_nxt;
			word_r <= word_nxt;
		end
	end

	// Output launched on rising edge so it is stable at the next sampling edge
	always_ff @(posedge serial_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			so_r <= 1'b0;
		end
		else
		begin
			so_r <= shift_r[FB-1];
		end
	end

	assign serial_out = so_r;
	assign serial_out_oe = spi_mode_lk && !frame_n && chain_enable;
	// Open drain: level only ever low, but sda_oe is tied low so the pin is never driven in either mode
	assign sda_o = 1'b0;
	// Bit timing on the two-wire bus lives outside; nothing here depends on its rate
	assign sda_oe = 1'b0;

	// Core domain synchronisers
	logic [1:0] ld_s_r, clr_s_r, rst_s_r, tgl_s_r, spi_s_r, pd_s_r, a0_s_r, a1_s_r;
	logic ld_d_r, clr_d_r, rst_d_r, tgl_d_r;
	always_ff @(posedge core_clk)
	begin
		ld_s_r <= {ld_s_r[0], load_outputs_n};
		clr_s_r <= {clr_s_r[0], clear_n};
		rst_s_r <= {rst_s_r[0], reset_n};
		tgl_s_r <= {tgl_s_r[0], word_tgl_r};
		spi_s_r <= {spi_s_r[0], iface_spi_sel};
		pd_s_r <= {pd_s_r[0], power_down};
		a0_s_r <= {a0_s_r[0], frame_n};
		a1_s_r <= {a1_s_r[0], chain_enable};
		if (sys_rst)
		begin
			ld_d_r <= 1'b1;
			clr_d_r <= 1'b1;
			rst_d_r <= 1'b1;
			tgl_d_r <= 1'b0;
		end
		else
		begin
			ld_d_r <= ld_s_r[1];
			clr_d_r <= clr_s_r[1];
			rst_d_r <= rst_s_r[1];
			tgl_d_r <= tgl_s_r[1];
		end
	end

	logic ld_fall, clr_fall, rst_fall, word_evt;
	assign ld_fall = ld_d_r && !ld_s_r[1];
	assign clr_fall = clr_d_r && !clr_s_r[1];
	assign rst_fall = rst_d_r && !rst_s_r[1];
	assign word_evt = tgl_d_r != tgl_s_r[1];

	// I2C address pins read on the shared frame and chain pins
	assign bus_addr = spi_s_r[1] ? 2'b00 : {a1_s_r[1], a0_s_r[1]};

	// Control state machine
	mdhc_state_t st_r, st_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	logic pend_r, pend_nxt;
	logic [2:0] fifo_cnt_r, fifo_cnt_nxt;
	logic [23:0] last_r, last_nxt;
	logic upd_r, upd_nxt;
	logic [4:0] mon_r, mon_nxt;

	always_comb
	begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		pend_nxt = pend_r;
		fifo_cnt_nxt = fifo_cnt_r;
		last_nxt = last_r;
		upd_nxt = 1'b0;
		mon_nxt = monitor_sel;
		// Writes queue in a small depth counter; past depth the count holds but last_word still takes the word
		if (word_evt && st_r != MDHC_RESET && spi_s_r[1])
		begin
			last_nxt = word_r;
			if (fifo_cnt_r != 3'(`MDHC_FIFO_DEPTH))
			begin
				fifo_cnt_nxt = fifo_cnt_r + 3'h1;
			end
		end
		unique case (st_r)
			MDHC_IDLE:
			begin
				if (ld_fall && clr_s_r[1] || pend_r)
				begin
					upd_nxt = 1'b1;
					pend_nxt = 1'b0;
					fifo_cnt_nxt = 3'h0;
				end
				else if (fifo_cnt_r != 3'h0)
				begin
					st_nxt = MDHC_CALC;
					cnt_nxt = 32'(`MDHC_CALC_CYC);
				end
			end
			MDHC_CALC:
			begin
				if (ld_fall && clr_s_r[1])
				begin
					pend_nxt = 1'b1;
				end
				cnt_nxt = cnt_r - 32'h1;
				if (cnt_r == 32'h1)
				begin
					st_nxt = MDHC_IDLE;
				end
			end
			MDHC_CLEAR:
			begin
				cnt_nxt = cnt_r - 32'h1;
				if (cnt_r == 32'h1)
				begin
					st_nxt = MDHC_IDLE;
					upd_nxt = 1'b1;
				end
			end
			MDHC_RESET:
			begin
				pend_nxt = 1'b0;
				fifo_cnt_nxt = 3'h0;
				cnt_nxt = cnt_r - 32'h1;
				if (cnt_r == 32'h1)
				begin
					st_nxt = MDHC_IDLE;
					last_nxt = 24'h000000;
				end
			end
		endcase
		if (clr_fall && st_r != MDHC_RESET)
		begin
			st_nxt = MDHC_CLEAR;
			cnt_nxt = 32'(CLR_CYC);
			pend_nxt = 1'b0;
		end
		if (rst_fall)
		begin
			st_nxt = MDHC_RESET;
			cnt_nxt = 32'(RST_CYC);
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			st_r <= MDHC_RESET;
			cnt_r <= 32'(RST_CYC);
			pend_r <= 1'b0;
			fifo_cnt_r <= 3'h0;
			last_r <= 24'h000000;
			upd_r <= 1'b0;
			mon_r <= 5'h00;
		end
		else
		begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			pend_r <= pend_nxt;
			fifo_cnt_r <= fifo_cnt_nxt;
			last_r <= last_nxt;
			upd_r <= upd_nxt;
			mon_r <= mon_nxt;
		end
	end

	assign busy_n = st_r == MDHC_IDLE;
	assign out_hiz = pd_s_r[1] && !pd_mode_load;
	assign out_load_gnd = pd_s_r[1] && pd_mode_load;
	assign monitor_route = mon_r;
	assign last_word = last_r;
	assign dac_update = upd_r;

	// Checks on the control state machine and on the address, data-line, power-down and monitor outputs
	a_busy_reset_len: assert property (@(posedge core_clk) disable iff (sys_rst)
		rst_fall |=> !busy_n [*8])
		else $error("busy rose early in reset");
	a_load_idle_upd: assert property (@(posedge core_clk) disable iff (sys_rst)
		st_r == MDHC_IDLE && ld_fall && clr_s_r[1] && !clr_fall && !rst_fall |=> dac_update)
		else $error("idle load did not update");
	a_calc_no_upd: assert property (@(posedge core_clk) disable iff (sys_rst)
		st_r == MDHC_CALC |=> !dac_update)
		else $error("update during calculation");
	a_pend_kept: assert property (@(posedge core_clk) disable iff (sys_rst)
		st_r == MDHC_CALC && ld_fall && clr_s_r[1] && !clr_fall && !rst_fall |=> pend_r)
		else $error("load during calc lost");
	a_reset_drop_ld: assert property (@(posedge core_clk) disable iff (sys_rst)
		st_r == MDHC_RESET |=> !pend_r)
		else $error("load stored in reset");
	a_clear_busy: assert property (@(posedge core_clk) disable iff (sys_rst)
		clr_fall && !rst_fall && st_r != MDHC_RESET |=> !busy_n [*8])
		else $error("clear busy too short");
	a_clr_low_ign: assert property (@(posedge core_clk) disable iff (sys_rst)
		!clr_s_r[1] && st_r == MDHC_CALC && !rst_fall |=> !pend_r || $past(pend_r))
		else $error("load taken while clear low");
	a_pd_outputs: assert property (@(posedge core_clk)
		!(out_hiz && out_load_gnd))
		else $error("both power-down modes");
	a_reset_cnt_load: assert property (@(posedge core_clk) disable iff (sys_rst)
		rst_fall |=> st_r == MDHC_RESET && cnt_r == 32'(RST_CYC))
		else $error("reset sequence not started");
	a_reset_done: assert property (@(posedge core_clk) disable iff (sys_rst)
		st_r == MDHC_RESET && cnt_r == 32'h1 && !rst_fall |=> busy_n && last_word == 24'h000000)
		else $error("reset sequence did not finish");
	a_reset_no_words: assert property (@(posedge core_clk) disable iff (sys_rst)
		st_r == MDHC_RESET |=> fifo_cnt_r == 3'h0)
		else $error("word queued during reset");
	a_clear_cnt_load: assert property (@(posedge core_clk) disable iff (sys_rst)
		clr_fall && !rst_fall && st_r != MDHC_RESET |=> st_r == MDHC_CLEAR && cnt_r == 32'(CLR_CYC))
		else $error("clear sequence not started");
	a_clear_end_upd: assert property (@(posedge core_clk) disable iff (sys_rst)
		st_r == MDHC_CLEAR && cnt_r == 32'h1 && !clr_fall && !rst_fall |=> dac_update)
		else $error("clear did not load channels");
	a_clear_no_pend: assert property (@(posedge core_clk) disable iff (sys_rst)
		st_r == MDHC_CLEAR |-> !pend_r)
		else $error("load held during clear");
	a_pend_applied: assert property (@(posedge core_clk) disable iff (sys_rst)
		st_r == MDHC_IDLE && pend_r && !clr_fall && !rst_fall |=> dac_update)
		else $error("stored load not applied");
	a_idle_no_spur: assert property (@(posedge core_clk) disable iff (sys_rst)
		st_r == MDHC_IDLE && !ld_fall && !pend_r |=> !dac_update)
		else $error("update without load");
	a_calc_enter: assert property (@(posedge core_clk) disable iff (sys_rst)
		st_r == MDHC_IDLE && fifo_cnt_r != 3'h0 && !ld_fall && !pend_r |=> !busy_n)
		else $error("queued word not calculated");
	a_fifo_bound: assert property (@(posedge core_clk) disable iff (sys_rst)
		fifo_cnt_r <= 3'(`MDHC_FIFO_DEPTH))
		else $error("word queue overfilled");
	a_word_capture: assert property (@(posedge core_clk) disable iff (sys_rst)
		word_evt && st_r != MDHC_RESET && spi_s_r[1] |=> last_word == $past(word_r))
		else $error("serial word not taken");
	a_addr_spi_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
		spi_s_r[1] |-> bus_addr == 2'b00)
		else $error("address pins read in serial mode");
	a_sda_low_only: assert property (@(posedge core_clk) disable iff (sys_rst)
		sda_oe |-> !sda_o)
		else $error("data line driven high");
	a_mon_follow: assert property (@(posedge core_clk) disable iff (sys_rst)
		!sys_rst |=> monitor_route == $past(monitor_sel))
		else $error("monitor route not followed");
	a_pd_select: assert property (@(posedge core_clk) disable iff (sys_rst)
		pd_s_r[1] |-> out_hiz || out_load_gnd)
		else $error("power-down output state missing");
endmodule

// ### testbench/mdhc_host_model.sv
// Host side model of the serial link: frame, clock and data
`timescale 1ns/1ps
module mdhc_host_model
(
	output logic serial_clk,
	output logic frame_n,
	output logic serial_in
);
	initial
	begin
		serial_clk = 1'b1;
		frame_n = 1'b1;
		serial_in = 1'b0;
	end
	task automatic send_word(input logic [23:0] w);
		#7 frame_n = 1'b0;
		for (int i = 23; i >= 0; i--)
		begin
			serial_in = w[i];
			#15 serial_clk = 1'b0;
			#15 serial_clk = 1'b1;
		end
		// Released data line flips so a stale bit is never mistaken for data
		serial_in = ~w[0];
		#15 frame_n = 1'b1;
	endtask
	task automatic set_frame(input logic v);
		frame_n = v;
	endtask
endmodule

// ### testbench/multichannel_dac_host_control_bench.sv
// Self-checking bench for the DAC host control block
`timescale 1ns/1ps
module multichannel_dac_host_control_bench;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic spi = 1'b1, chain = 1'b0, ld_n = 1'b1, clr_n = 1'b1, rst_n = 1'b1;
	logic pd = 1'b0, pdl = 1'b0, sclk, fr_n, sin;
	logic [4:0] msel = 5'h00;
	logic sda_o, sda_oe, sout, sout_oe, busy_n, hiz, lgnd, upd;
	logic [4:0] mroute;
	logic [1:0] baddr;
	logic [23:0] lword;
	logic [23:0] exp_q[$];
	int fails = 0, samples_checked = 0, seed = 14195, n;
	always #5 core_clk = ~core_clk;
	mdhc_host_model mdhc_host_model_inst (.serial_clk(sclk), .frame_n(fr_n), .serial_in(sin));
	mdhc_ctrl #(.CLR_CYC(20), .RST_CYC(30)) mdhc_ctrl_inst (.core_clk(core_clk),
		.sys_rst(sys_rst), .serial_clk(sclk), .iface_spi_sel(spi), .frame_n(fr_n),
		.chain_enable(chain), .serial_in(sin), .sda_o(sda_o), .sda_oe(sda_oe),
		.serial_out(sout), .serial_out_oe(sout_oe), .load_outputs_n(ld_n),
		.clear_n(clr_n), .reset_n(rst_n), .power_down(pd), .pd_mode_load(pdl),
		.busy_n(busy_n), .out_hiz(hiz), .out_load_gnd(lgnd), .monitor_sel(msel),
		.monitor_route(mroute), .bus_addr(baddr), .last_word(lword), .dac_update(upd));
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic test_done();
		if (fails == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	task automatic cnt_upd(input int k, output int c);
		c = 0;
		repeat (k)
		begin
			step(1);
			c += (upd === 1'b1);
		end
	endtask
	task automatic wait_idle(output int c);
		c = 0;
		while (busy_n !== 1'b1 && c < 5000)
		begin
			step(1);
			c++;
		end
		if (c >= 5000)
			fails++;
	endtask
	// Held for several cycles so the synchroniser cannot miss it
	task automatic pulse_load();
		@(posedge core_clk);
		ld_n <= 1'b0;
		repeat (4) @(posedge core_clk);
		ld_n <= 1'b1;
	endtask
	task automatic send(output logic [23:0] w);
		w = $random(seed);
		exp_q.push_back(w);
		mdhc_host_model_inst.send_word(w);
		step(6);
	endtask
	initial
	begin
		logic [23:0] w;
		step(16);
		sys_rst <= 1'b0;
		fork pulse_load(); cnt_upd(20, n); join
		check("upd_in_rst", n, 0);
		check("busy_rst", busy_n, 0);
		wait_idle(n);
		check("rst_len", (n + 20 >= 28 && n + 20 <= 33), 1);
		fork pulse_load(); cnt_upd(10, n); join
		check("upd_idle", n, 1);
		send(w);
		check("word", lword, exp_q.pop_front());
		check("sout", sout, w[23]);
		check("busy_calc", busy_n, 0);
		fork pulse_load(); cnt_upd(8, n); join
		check("upd_calc", n, 0);
		wait_idle(n);
		cnt_upd(4, n);
		check("upd_pend", n, 1);
		for (int i = 0; i < 2; i++)
		begin
			pd <= 1'b1;
			pdl <= i[0];
			step(5);
			check("pd_out", {hiz, lgnd}, {~i[0], i[0]});
			send(w);
			check("pd_word", lword, exp_q.pop_front());
			wait_idle(n);
		end
		pd <= 1'b0;
		chain <= 1'b1;
		step(2);
		check("oe_idle", sout_oe, 0);
		mdhc_host_model_inst.set_frame(1'b0);
		step(1);
		check("oe_chain", sout_oe, 1);
		mdhc_host_model_inst.set_frame(1'b1);
		chain <= 1'b0;
		clr_n <= 1'b0;
		fork pulse_load(); cnt_upd(12, n); join
		check("upd_clr", n, 0);
		check("busy_clr", busy_n, 0);
		wait_idle(n);
		check("clr_len", (n + 12 >= 22 && n + 12 <= 26), 1);
		check("upd_clr_end", upd, 1);
		fork pulse_load(); cnt_upd(10, n); join
		check("upd_clr_low", n, 0);
		clr_n <= 1'b1;
		rst_n <= 1'b0;
		fork pulse_load(); cnt_upd(12, n); join
		check("upd_rst_pin", n, 0);
		check("busy_rst_pin", busy_n, 0);
		wait_idle(n);
		check("rst_pin_len", (n + 12 >= 31 && n + 12 <= 35), 1);
		check("lword_rst", lword, 0);
		step(5);
		check("rst_lvl_ign", busy_n, 1);
		rst_n <= 1'b1;
		spi <= 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			chain <= i[1];
			msel <= $random(seed);
			mdhc_host_model_inst.set_frame(i[0]);
			step(5);
			check("addr", baddr, i[1:0]);
			check("sda", sda_oe & sda_o, 0);
			check("mon", mroute, msel);
		end
		test_done();
	end
	initial
	begin
		#100000;
		fails++;
		test_done();
	end
endmodule
